// ---- verilog/pc_call_stack.sv ----
`default_nettype none

`include "pc_stack_defs.svh"

module pc_call_stack #(
    parameter logic [`PC_WIDTH-1:0] VECTOR_ADDR = `VECTOR_DEFAULT
) (
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      cmd_valid_in,
    input  wire pc_stack_pkg::cmd_t        cmd_in,
    input  wire logic                      latch_wr_in,
    input  wire logic [`DATA_WIDTH-1:0]    latch_data_in,
    output var  logic [`PC_WIDTH-1:0]      pc_out,
    output var  logic [`LOW_WIDTH-1:0]     counter_low_byte_reg_out,
    output var  logic [`DATA_WIDTH-1:0]    high_address_holding_latch_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    pc_stack_pkg::pc_state_t       state;
    pc_stack_pkg::pc_state_t       next_state;

    logic                          push;
    logic                          pop;
    logic [`PTR_WIDTH-1:0]         ptr;
    logic [`PTR_WIDTH-1:0]         next_ptr;
    logic [`PTR_WIDTH-1:0]         rd_addr;
    logic [`PC_WIDTH-1:0]          push_value;
    logic [`PC_WIDTH-1:0]          top_value;
    logic [`PC_WIDTH-1:0]          seq_pc;
    logic [`PC_WIDTH-1:0]          branch_pc;
    logic [`PC_WIDTH-1:0]          low_write_pc;
    logic [`UPPER_WIDTH-1:0]       counter_upper_bits;

    // ----------------------------------------
    // address candidates
    // ----------------------------------------
    always_comb begin
        seq_pc = state.pc + `PC_STEP;
    end

    always_comb begin
        branch_pc = {state.latch[`LATCH_MSB:`LATCH_PAGE_LSB],
                     cmd_in.target};
    end

    always_comb begin
        counter_upper_bits = state.latch;
        low_write_pc       = {counter_upper_bits, cmd_in.data};
    end

    // ----------------------------------------
    // stack control
    // ----------------------------------------
    always_comb begin
        push       = 1'b0;
        pop        = 1'b0;
        push_value = seq_pc;
        if (cmd_valid_in) begin
            case (cmd_in.op)
                pc_stack_pkg::OP_CALL: begin
                    push       = 1'b1;
                    push_value = seq_pc;
                end
                pc_stack_pkg::OP_IRQ: begin
                    push       = 1'b1;
                    push_value = state.pc;
                end
                pc_stack_pkg::OP_RETURN,
                pc_stack_pkg::OP_RET_LIT,
                pc_stack_pkg::OP_RET_INT: begin
                    pop = 1'b1;
                end
                default: begin
                    push = 1'b0;
                    pop  = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        rd_addr = next_ptr - `PTR_STEP;
    end

    // ----------------------------------------
    // hidden pointer and storage
    // ----------------------------------------
    stack_pointer u_stack_pointer (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .push_in      (push),
        .pop_in       (pop),
        .ptr_out      (ptr),
        .next_ptr_out (next_ptr)
    );

    return_stack_mem #(
        .DEPTH  (`STACK_DEPTH),
        .WIDTH  (`PC_WIDTH),
        .ADDR_W (`PTR_WIDTH)
    ) u_return_stack_mem (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (push),
        .wr_addr_in  (ptr),
        .wr_data_in  (push_value),
        .rd_addr_in  (rd_addr),
        .rd_data_out (top_value)
    );

    // ----------------------------------------
    // program counter and holding latch
    // ----------------------------------------
    always_comb begin
        next_state = state;
        if (latch_wr_in) begin
            next_state.latch = latch_data_in[`LATCH_MSB:0];
        end
        if (cmd_valid_in) begin
            case (cmd_in.op)
                pc_stack_pkg::OP_STEP: begin
                    next_state.pc = seq_pc;
                end
                pc_stack_pkg::OP_WRITE_LOW: begin
                    next_state.pc = low_write_pc;
                end
                pc_stack_pkg::OP_JUMP,
                pc_stack_pkg::OP_CALL: begin
                    next_state.pc = branch_pc;
                end
                pc_stack_pkg::OP_IRQ: begin
                    next_state.pc = VECTOR_ADDR;
                end
                pc_stack_pkg::OP_RETURN,
                pc_stack_pkg::OP_RET_LIT,
                pc_stack_pkg::OP_RET_INT: begin
                    next_state.pc = top_value;
                end
                default: begin
                    next_state.pc = state.pc;
                end
            endcase
        end
        next_state.low_byte = next_state.pc[`PC_LOW_MSB:0];
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state.pc       <= `PC_RESET;
            state.latch    <= `LATCH_RESET;
            state.low_byte <= `LOW_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign pc_out                         = state.pc;
    assign counter_low_byte_reg_out       = state.low_byte;
    assign high_address_holding_latch_out = {3'h0, state.latch};

endmodule

`default_nettype wire

// ---- verilog/pc_stack_defs.svh ----
`ifndef PC_STACK_DEFS_SVH
`define PC_STACK_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define PC_WIDTH        13
`define LOW_WIDTH       8
`define UPPER_WIDTH     5
`define TARGET_WIDTH    11
`define DATA_WIDTH      8
`define STACK_DEPTH     8
`define PTR_WIDTH       3

// ----------------------------------------
// field positions
// ----------------------------------------
`define PC_LOW_MSB      7
`define PC_UPPER_LSB    8
`define PC_MSB          12
`define PC_PAGE_LSB     11
`define LATCH_MSB       4
`define LATCH_PAGE_LSB  3

// ----------------------------------------
// reset values and steps
// ----------------------------------------
`define PC_RESET        13'h0000
`define LATCH_RESET     5'h00
`define LOW_RESET       8'h00
`define PTR_RESET       3'h0
`define PTR_STEP        3'h1
`define PC_STEP         13'h0001
`define VECTOR_DEFAULT  13'h0004

`endif

// ---- verilog/pc_stack_pkg.sv ----
`default_nettype none

`include "pc_stack_defs.svh"

package pc_stack_pkg;

    // ----------------------------------------
    // core operations, one per accepted cycle
    // ----------------------------------------
    typedef enum logic [7:0] {
        OP_STEP      = 8'h01,
        OP_WRITE_LOW = 8'h02,
        OP_JUMP      = 8'h04,
        OP_CALL      = 8'h08,
        OP_RETURN    = 8'h10,
        OP_RET_LIT   = 8'h20,
        OP_RET_INT   = 8'h40,
        OP_IRQ       = 8'h80
    } op_t;

    // ----------------------------------------
    // request carried from the decoder
    // ----------------------------------------
    typedef struct packed {
        op_t                        op;
        logic [`TARGET_WIDTH-1:0]   target;
        logic [`DATA_WIDTH-1:0]     data;
    } cmd_t;

    // ----------------------------------------
    // block state
    // ----------------------------------------
    typedef struct packed {
        logic [`PC_WIDTH-1:0]       pc;
        logic [`UPPER_WIDTH-1:0]    latch;
        logic [`LOW_WIDTH-1:0]      low_byte;
    } pc_state_t;

    typedef struct packed {
        logic [`PTR_WIDTH-1:0]      ptr;
    } ptr_state_t;

endpackage

`default_nettype wire

// ---- verilog/return_stack_mem.sv ----
`default_nettype none

`include "pc_stack_defs.svh"

module return_stack_mem #(
    parameter int DEPTH     = `STACK_DEPTH,
    parameter int WIDTH     = `PC_WIDTH,
    parameter int ADDR_W    = `PTR_WIDTH
) (
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [WIDTH-1:0]  wr_data_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output var  logic [WIDTH-1:0]  rd_data_out
);

    // ----------------------------------------
    // storage, separate from program and data space
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rd_data;

    always_comb begin
        if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
            next_rd_data = wr_data_in;
        end else begin
            next_rd_data = mem[rd_addr_in];
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/stack_pointer.sv ----
`default_nettype none

`include "pc_stack_defs.svh"

module stack_pointer (
    input  wire logic                  clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  push_in,
    input  wire logic                  pop_in,
    output var  logic [`PTR_WIDTH-1:0] ptr_out,
    output var  logic [`PTR_WIDTH-1:0] next_ptr_out
);

    // ----------------------------------------
    // circular pointer, wraps silently both ways
    // ----------------------------------------
    pc_stack_pkg::ptr_state_t state;
    pc_stack_pkg::ptr_state_t next_state;

    always_comb begin
        next_state = state;
        if (push_in) begin
            next_state.ptr = state.ptr + `PTR_STEP;
        end else if (pop_in) begin
            next_state.ptr = state.ptr - `PTR_STEP;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state.ptr <= `PTR_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign ptr_out      = state.ptr;
    assign next_ptr_out = next_state.ptr;

endmodule

`default_nettype wire

// ---- verif/pc_call_stack_assertions.sv ----
`default_nettype none
`include "pc_stack_defs.svh"
module pc_call_stack_checker #(
    parameter logic [`PC_WIDTH-1:0] VECTOR_ADDR = `VECTOR_DEFAULT
) (
    input wire logic                   clk_in,
    input wire logic                   sys_rst_in,
    input wire logic                   cmd_valid_in,
    input wire pc_stack_pkg::cmd_t     cmd_in,
    input wire logic                   latch_wr_in,
    input wire logic [`DATA_WIDTH-1:0] latch_data_in,
    input wire logic [`PC_WIDTH-1:0]   pc_out,
    input wire logic [`LOW_WIDTH-1:0]  counter_low_byte_reg_out,
    input wire logic [`DATA_WIDTH-1:0] high_address_holding_latch_out
);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    pc_stack_pkg::op_t op;
    assign op = cmd_in.op;
    wire logic [4:0] lat = high_address_holding_latch_out[4:0];
    sequence s_call; cmd_valid_in && op == pc_stack_pkg::OP_CALL; endsequence
    sequence s_ret; cmd_valid_in && op == pc_stack_pkg::OP_RETURN; endsequence
    chk_reset_clear: assert property (disable iff (1'b0) sys_rst_in |-> pc_out == '0)
        else $error("pc not cleared in reset");
    chk_low_write: assert property (cmd_valid_in && op == pc_stack_pkg::OP_WRITE_LOW |=>
        counter_low_byte_reg_out == $past(cmd_in.data)) else $error("low byte not written");
    chk_upper_load: assert property (cmd_valid_in && op == pc_stack_pkg::OP_WRITE_LOW |=>
        pc_out[12:8] == $past(lat)) else $error("upper bits not from latch");
    chk_page_load: assert property (cmd_valid_in && (op == pc_stack_pkg::OP_JUMP ||
        op == pc_stack_pkg::OP_CALL) |=> pc_out == {$past(lat[4:3]), $past(cmd_in.target)})
        else $error("jump target wrong");
    chk_step_incr: assert property (cmd_valid_in && op == pc_stack_pkg::OP_STEP |=>
        pc_out == $past(pc_out) + `PC_STEP) else $error("step not plus one");
    chk_idle_hold: assert property (!cmd_valid_in |=> $stable(pc_out))
        else $error("pc moved while idle");
    chk_irq_vector: assert property (cmd_valid_in && op == pc_stack_pkg::OP_IRQ |=>
        pc_out == VECTOR_ADDR) else $error("vector not taken");
    chk_call_return: assert property (s_call ##1 s_ret |=>
        pc_out == $past(pc_out, 2) + `PC_STEP) else $error("return address wrong");
    chk_latch_kept: assert property (cmd_valid_in && !latch_wr_in && op inside
        {pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_IRQ, pc_stack_pkg::OP_RETURN,
        pc_stack_pkg::OP_RET_LIT, pc_stack_pkg::OP_RET_INT} |=>
        $stable(high_address_holding_latch_out)) else $error("latch changed by stack");
endmodule
bind pc_call_stack pc_call_stack_checker #(.VECTOR_ADDR(VECTOR_ADDR)) chk_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .latch_wr_in(latch_wr_in), .latch_data_in(latch_data_in),
    .pc_out(pc_out), .counter_low_byte_reg_out(counter_low_byte_reg_out),
    .high_address_holding_latch_out(high_address_holding_latch_out));
`default_nettype wire

// ---- verif/core_decoder_model.sv ----
`default_nettype none
module core_decoder_model (
    input  wire logic               clk_in,
    output var  logic               cmd_valid_out,
    output var  pc_stack_pkg::cmd_t cmd_out,
    output var  logic               latch_wr_out,
    output var  logic [7:0]         latch_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // decoder side
    // ----------------
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
        latch_wr_out = 1'b0;
        latch_data_out = 8'h00;
    end
    // computed offsets stay inside one 256 block
    task automatic issue(input pc_stack_pkg::op_t op, input logic [10:0] t,
                         input logic [7:0] d, input logic lw, input logic [7:0] ld);
        cmd_valid_out = 1'b1;
        cmd_out = {op, t, d};
        latch_wr_out = lw;
        latch_data_out = ld;
        @(posedge clk_in);
        #1;
    endtask
    // released lines show inverted data
    task automatic idle;
        cmd_valid_out = 1'b0;
        latch_wr_out = 1'b0;
        cmd_out.data = ~cmd_out.data;
        latch_data_out = ~latch_data_out;
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        pc_stack_pkg::op_t op;
        logic [10:0]       t;
        logic [7:0]        d, ld, lat;
        logic              lw;
        logic [12:0]       pc;
    } row_t;
    logic               clk_in = 1'b0;
    logic               sys_rst_in = 1'b0;
    logic               cmd_valid, latch_wr;
    pc_stack_pkg::cmd_t cmd;
    logic [7:0]         latch_data, low, lat;
    logic [12:0]        pc;
    int                 err_total = 0;
    int                 n_tests = 0;
    row_t rows [10] = '{
        '{pc_stack_pkg::OP_STEP, 11'h0, 8'h00, 8'h1f, 8'h1f, 1'b1, 13'h0001},
        '{pc_stack_pkg::OP_WRITE_LOW, 11'h0, 8'h34, 8'h00, 8'h1f, 1'b0, 13'h1f34},
        '{pc_stack_pkg::OP_JUMP, 11'h123, 8'h00, 8'h00, 8'h1f, 1'b0, 13'h1923},
        '{pc_stack_pkg::OP_STEP, 11'h0, 8'h00, 8'h00, 8'h1f, 1'b0, 13'h1924},
        '{pc_stack_pkg::OP_CALL, 11'h050, 8'h00, 8'h08, 8'h08, 1'b1, 13'h1850},
        '{pc_stack_pkg::OP_IRQ, 11'h0, 8'h00, 8'h00, 8'h08, 1'b0, 13'h0004},
        '{pc_stack_pkg::OP_RET_INT, 11'h0, 8'h00, 8'h00, 8'h08, 1'b0, 13'h1850},
        '{pc_stack_pkg::OP_RETURN, 11'h0, 8'h00, 8'h00, 8'h08, 1'b0, 13'h1925},
        '{pc_stack_pkg::OP_CALL, 11'h7ff, 8'h00, 8'h00, 8'h08, 1'b0, 13'h0fff},
        '{pc_stack_pkg::OP_RET_LIT, 11'h0, 8'h00, 8'h00, 8'h08, 1'b0, 13'h1926}};
    // ----------------
    // harness
    // ----------------
    always #10 clk_in = ~clk_in;
    core_decoder_model dec_u (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
        .latch_wr_out(latch_wr), .latch_data_out(latch_data));
    pc_call_stack dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid),
        .cmd_in(cmd), .latch_wr_in(latch_wr), .latch_data_in(latch_data), .pc_out(pc),
        .counter_low_byte_reg_out(low), .high_address_holding_latch_out(lat));
    task automatic check_pc(input logic [12:0] e);
        n_tests++;
        if (pc !== e || low !== e[7:0]) begin
            err_total++;
            $display("[FAIL] pc_out expected %h seen %h low %h", e, pc, low);
        end
    endtask
    task automatic check_lat(input logic [7:0] e);
        n_tests++;
        if (lat !== e) begin
            err_total++;
            $display("[FAIL] latch expected %h seen %h", e, lat);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #5000;
        err_total++;
        print_verdict();
    end
    initial begin
        #1 sys_rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        check_pc(13'h0000);
        foreach (rows[i]) begin
            dec_u.issue(rows[i].op, rows[i].t, rows[i].d, rows[i].lw, rows[i].ld);
            check_pc(rows[i].pc);
            check_lat(rows[i].lat);
        end
        dec_u.idle();
        @(posedge clk_in);
        #1 check_pc(13'h1926);
        $display("table rows done");
        sys_rst_in = 1'b1;
        @(posedge clk_in);
        #1 check_pc(13'h0000);
        check_lat(8'h00);
        @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        $display("mid-run reset done");
        for (int k = 1; k <= 9; k++) begin
            dec_u.issue(pc_stack_pkg::OP_CALL, 11'(16 * k), 8'h00, 1'b0, 8'h00);
            check_pc(13'(16 * k));
        end
        for (int j = 1; j <= 9; j++) begin
            dec_u.issue(pc_stack_pkg::OP_RETURN, 11'h0, 8'h00, 1'b0, 8'h00);
            check_pc(13'((j == 9) ? 129 : 16 * (9 - j) + 1));
        end
        $display("stack wrap done");
        print_verdict();
    end
endmodule
`default_nettype wire
